/* File: rtl/iqpc_regs.sv */
/*
  iqpc_regs: staged and active correction coefficients, register port,
  auto-sync on phase register writes, and the correction datapath.
  assumes: master strobes are one cycle, never both at once.
*/
// Strobed register access was decided locally.
`timescale 1ns/10ps
module iqpc_regs
  import iqpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic ext_sync,
  input wire logic signed [IQPC_SAMPLE_W-1:0] a_in,
  input wire logic signed [IQPC_SAMPLE_W-1:0] b_in,
  output logic signed [IQPC_SAMPLE_W-1:0] a_out,
  output logic signed [IQPC_SAMPLE_W-1:0] b_out,
  output logic sync_seen
);
  // ----------------------------------------------------------------
  // staged registers
  // ----------------------------------------------------------------
  logic [15:0] phase_ctrl_ff, gain_a_ff, gain_b_ff, sync_setup_ff, ofs_a_ff, ofs_b_ff;
  logic [15:0] nxt_phase_ctrl, nxt_gain_a, nxt_gain_b, nxt_sync_setup, nxt_ofs_a, nxt_ofs_b;
  logic [15:0] rdata_ff, nxt_rdata;
  logic sync_seen_ff, nxt_sync_seen;
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
  // filtered pin level and its rising edge
  logic ext_lvl_ff, nxt_ext_lvl, ext_rise;

  function automatic logic iqpc_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  always_comb begin
    nxt_phase_ctrl = phase_ctrl_ff;
    nxt_gain_a = gain_a_ff;
    nxt_gain_b = gain_b_ff;
    nxt_sync_setup = sync_setup_ff;
    nxt_ofs_a = ofs_a_ff;
    nxt_ofs_b = ofs_b_ff;
    if (reg_wr) begin
      // bits 12/13 are stored as written; host must set them
      if (iqpc_hit(reg_addr, IQPC_PHASE_CTRL_OFS)) begin
        nxt_phase_ctrl = reg_wdata;
      end
      if (iqpc_hit(reg_addr, IQPC_CHAN_A_GAIN_OFS)) begin
        nxt_gain_a = {5'h00, reg_wdata[IQPC_GAIN_W-1:0]};
      end
      if (iqpc_hit(reg_addr, IQPC_CHAN_B_GAIN_OFS)) begin
        nxt_gain_b = {5'h00, reg_wdata[IQPC_GAIN_W-1:0]};
      end
      if (iqpc_hit(reg_addr, IQPC_SYNC_SETUP_OFS)) begin
        nxt_sync_setup = reg_wdata;
      end
      if (iqpc_hit(reg_addr, IQPC_OFFSET_A_OFS)) begin
        nxt_ofs_a = {3'h0, reg_wdata[IQPC_OFFSET_W-1:0]};
      end
      if (iqpc_hit(reg_addr, IQPC_OFFSET_B_OFS)) begin
        nxt_ofs_b = {3'h0, reg_wdata[IQPC_OFFSET_W-1:0]};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_ctrl_ff <= IQPC_PHASE_RST;
      gain_a_ff <= IQPC_GAIN_RST;
      gain_b_ff <= IQPC_GAIN_RST;
      sync_setup_ff <= IQPC_SYNC_RST;
      ofs_a_ff <= IQPC_OFFSET_RST;
      ofs_b_ff <= IQPC_OFFSET_RST;
    end else begin
      phase_ctrl_ff <= nxt_phase_ctrl;
      gain_a_ff <= nxt_gain_a;
      gain_b_ff <= nxt_gain_b;
      sync_setup_ff <= nxt_sync_setup;
      ofs_a_ff <= nxt_ofs_a;
      ofs_b_ff <= nxt_ofs_b;
    end
  end

  // ----------------------------------------------------------------
  // sync and active coefficients
  // ----------------------------------------------------------------
  // external sync comes from a pin: three flops, and a level change counts
  // only once stages 2 and 3 agree, so a runt pulse on the pin is dropped
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      ext_lvl_ff <= 1'b0;
    end else begin
      ext_s1_ff <= ext_sync;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      ext_lvl_ff <= nxt_ext_lvl;
    end
  end

  // the filtered level resets to the pin's idle low, so no false edge
  // follows reset
  always_comb begin
    nxt_ext_lvl = ext_lvl_ff;
    if (ext_s2_ff == ext_s3_ff) begin
      nxt_ext_lvl = ext_s3_ff;
    end
  end

  logic auto_sync, do_sync;
  assign ext_rise = nxt_ext_lvl && !ext_lvl_ff;
  assign auto_sync = reg_wr && iqpc_hit(reg_addr, IQPC_PHASE_CTRL_OFS)
                     && sync_setup_ff[IQPC_AUTOSYNC_BIT];
  // a pin edge and a phase write in one cycle make a single sync
  assign do_sync = auto_sync || ext_rise;

  logic [IQPC_GAIN_W-1:0] act_gain_a_ff, act_gain_b_ff, nxt_act_gain_a, nxt_act_gain_b;
  logic [IQPC_PHASE_W-1:0] act_phase_ff, nxt_act_phase;
  logic [IQPC_OFFSET_W-1:0] act_ofs_a_ff, act_ofs_b_ff, nxt_act_ofs_a, nxt_act_ofs_b;

  // the phase word is taken from the write data so the sync that the
  // write raises carries the new value, not the one it replaces
  always_comb begin
    nxt_act_gain_a = act_gain_a_ff;
    nxt_act_gain_b = act_gain_b_ff;
    nxt_act_phase = act_phase_ff;
    nxt_act_ofs_a = act_ofs_a_ff;
    nxt_act_ofs_b = act_ofs_b_ff;
    nxt_sync_seen = sync_seen_ff;
    if (do_sync) begin
      nxt_act_gain_a = gain_a_ff[IQPC_GAIN_W-1:0];
      nxt_act_gain_b = gain_b_ff[IQPC_GAIN_W-1:0];
      nxt_act_phase = nxt_phase_ctrl[IQPC_PHASE_W-1:0];
      nxt_act_ofs_a = ofs_a_ff[IQPC_OFFSET_W-1:0];
      nxt_act_ofs_b = ofs_b_ff[IQPC_OFFSET_W-1:0];
      nxt_sync_seen = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_gain_a_ff <= IQPC_GAIN_RST[IQPC_GAIN_W-1:0];
      act_gain_b_ff <= IQPC_GAIN_RST[IQPC_GAIN_W-1:0];
      act_phase_ff <= IQPC_PHASE_RST[IQPC_PHASE_W-1:0];
      act_ofs_a_ff <= IQPC_OFFSET_RST[IQPC_OFFSET_W-1:0];
      act_ofs_b_ff <= IQPC_OFFSET_RST[IQPC_OFFSET_W-1:0];
      sync_seen_ff <= 1'b0;
    end else begin
      act_gain_a_ff <= nxt_act_gain_a;
      act_gain_b_ff <= nxt_act_gain_b;
      act_phase_ff <= nxt_act_phase;
      act_ofs_a_ff <= nxt_act_ofs_a;
      act_ofs_b_ff <= nxt_act_ofs_b;
      sync_seen_ff <= nxt_sync_seen;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        IQPC_PHASE_CTRL_OFS: nxt_rdata = phase_ctrl_ff;
        IQPC_CHAN_A_GAIN_OFS: nxt_rdata = gain_a_ff;
        IQPC_CHAN_B_GAIN_OFS: nxt_rdata = gain_b_ff;
        IQPC_SYNC_SETUP_OFS: nxt_rdata = sync_setup_ff;
        IQPC_OFFSET_A_OFS: nxt_rdata = ofs_a_ff;
        IQPC_OFFSET_B_OFS: nxt_rdata = ofs_b_ff;
        IQPC_SPARE_OFS: nxt_rdata = IQPC_SPARE_RST;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign sync_seen = sync_seen_ff;

  // ----------------------------------------------------------------
  // correction datapath
  // ----------------------------------------------------------------
  iqpc_datapath u_dp (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .a_in(a_in),
    .b_in(b_in),
    .gain_a(act_gain_a_ff),
    .gain_b(act_gain_b_ff),
    .phase(act_phase_ff),
    .ofs_a(act_ofs_a_ff),
    .ofs_b(act_ofs_b_ff),
    .a_out(a_out),
    .b_out(b_out)
  );
endmodule

/* File: rtl/iqpc_pkg.sv */
/*
  iqpc_pkg: register offsets, field layout and reset values of the
  quadrature phase/gain correction control block.
  assumes: 16-bit register port, one clock domain.
*/
package iqpc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IQPC_CHAN_A_GAIN_OFS = 8'h0c;
  localparam logic [7:0] IQPC_CHAN_B_GAIN_OFS = 8'h0d;
  localparam logic [7:0] IQPC_PHASE_CTRL_OFS = 8'h10;
  localparam logic [7:0] IQPC_SPARE_OFS = 8'h11;
  localparam logic [7:0] IQPC_SYNC_SETUP_OFS = 8'h1e;
  localparam logic [7:0] IQPC_OFFSET_A_OFS = 8'h20;
  localparam logic [7:0] IQPC_OFFSET_B_OFS = 8'h21;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int IQPC_PHASE_W = 12;
  localparam int IQPC_GAIN_W = 11;
  localparam int IQPC_GAIN_FRAC = 10;
  localparam int IQPC_PHASE_FRAC = 12;
  localparam int IQPC_OFFSET_W = 13;
  localparam int IQPC_SAMPLE_W = 16;
  localparam int IQPC_AUTOSYNC_BIT = 0;
  localparam logic [15:0] IQPC_PHASE_RST = 16'h0000;
  localparam logic [15:0] IQPC_GAIN_RST = 16'h0400;
  localparam logic [15:0] IQPC_SPARE_RST = 16'h0000;
  localparam logic [15:0] IQPC_SYNC_RST = 16'h0000;
  localparam logic [15:0] IQPC_OFFSET_RST = 16'h0000;
endpackage

/* File: rtl/iqpc_datapath.sv */
/*
  iqpc_datapath: applies gain, phase and offset correction to one
  sample pair per clock, registered output.
  assumes: coefficients are held stable by the caller between syncs.
*/
`timescale 1ns/10ps
module iqpc_datapath
  import iqpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic signed [IQPC_SAMPLE_W-1:0] a_in,
  input wire logic signed [IQPC_SAMPLE_W-1:0] b_in,
  input wire logic [IQPC_GAIN_W-1:0] gain_a,
  input wire logic [IQPC_GAIN_W-1:0] gain_b,
  input wire logic signed [IQPC_PHASE_W-1:0] phase,
  input wire logic signed [IQPC_OFFSET_W-1:0] ofs_a,
  input wire logic signed [IQPC_OFFSET_W-1:0] ofs_b,
  output logic signed [IQPC_SAMPLE_W-1:0] a_out,
  output logic signed [IQPC_SAMPLE_W-1:0] b_out
);
  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  logic signed [IQPC_SAMPLE_W-1:0] a_out_ff, b_out_ff;
  logic signed [IQPC_SAMPLE_W-1:0] nxt_a_out, nxt_b_out;

  // saturate instead of wrapping: a wrap is a full-scale glitch
  function automatic logic signed [IQPC_SAMPLE_W-1:0] iqpc_sat(input logic signed [31:0] v);
    if (v > 32'sd32767) begin
      return 16'sh7fff;
    end else if (v < -32'sd32768) begin
      return 16'sh8000;
    end else begin
      return v[IQPC_SAMPLE_W-1:0];
    end
  endfunction

  always_comb begin
    logic signed [31:0] ga, gb, ph;
    ga = (32'(a_in) * $signed({21'h0, gain_a})) >>> IQPC_GAIN_FRAC;
    gb = (32'(b_in) * $signed({21'h0, gain_b})) >>> IQPC_GAIN_FRAC;
    ph = (32'(b_in) * 32'(phase)) >>> IQPC_PHASE_FRAC;
    nxt_a_out = iqpc_sat(ga + ph + 32'(ofs_a));
    nxt_b_out = iqpc_sat(gb + 32'(ofs_b));
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      a_out_ff <= 16'sh0000;
      b_out_ff <= 16'sh0000;
    end else begin
      a_out_ff <= nxt_a_out;
      b_out_ff <= nxt_b_out;
    end
  end

  assign a_out = a_out_ff;
  assign b_out = b_out_ff;
endmodule

/* File: test/iqpc_asserts.sv */
/*
  iqpc_asserts: port checks bound to iqpc_regs.
  assumes: ext_sync stays low until the first auto-sync has been seen.
*/
`timescale 1ns/10ps
module iqpc_asserts
  import iqpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic signed [IQPC_SAMPLE_W-1:0] a_in,
  input wire logic signed [IQPC_SAMPLE_W-1:0] b_in,
  input wire logic signed [IQPC_SAMPLE_W-1:0] a_out,
  input wire logic sync_seen
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // shadow of the auto-sync enable, needed to know when a phase write must sync
  // ----
  logic auto_en_ff;
  logic nxt_auto_en;
  always_comb begin
    nxt_auto_en = auto_en_ff;
    if (reg_wr && reg_addr == IQPC_SYNC_SETUP_OFS) nxt_auto_en = reg_wdata[IQPC_AUTOSYNC_BIT];
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) auto_en_ff <= 1'h0;
    else auto_en_ff <= nxt_auto_en;
  end
  sequence s_ph_wr;
    reg_wr && reg_addr == IQPC_PHASE_CTRL_OFS;
  endsequence
  sequence s_ph_rd;
    reg_rd && reg_addr == IQPC_PHASE_CTRL_OFS;
  endsequence
  chk_phase_readback: assert property (s_ph_wr ##1 s_ph_rd |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("phase readback wrong");
  chk_spare_zero: assert property (reg_rd && reg_addr == IQPC_SPARE_OFS |=>
    reg_rdata == 16'h0000) else $error("spare word not zero");
  chk_gain_a_mask: assert property (reg_rd && reg_addr == IQPC_CHAN_A_GAIN_OFS |=>
    reg_rdata[15:11] == 5'h00) else $error("gain a upper bits set");
  chk_gain_b_mask: assert property (reg_rd && reg_addr == IQPC_CHAN_B_GAIN_OFS |=>
    reg_rdata[15:11] == 5'h00) else $error("gain b upper bits set");
  chk_auto_sync: assert property (s_ph_wr and auto_en_ff |=> sync_seen)
    else $error("phase write gave no sync");
  chk_no_auto: assert property (s_ph_wr and !auto_en_ff && !sync_seen |=> !sync_seen)
    else $error("sync without enable");
  chk_out_hold: assert property (!sync_seen && !$past(sys_rst) && $stable(a_in)
    && $stable(b_in) |=> $stable(a_out) || sync_seen) else $error("output moved without sync");
  chk_sync_sticky: assert property (sync_seen |=> sync_seen)
    else $error("sync flag dropped");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
endmodule
bind iqpc_regs iqpc_asserts iqpc_asserts_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .a_in(a_in), .b_in(b_in), .a_out(a_out), .sync_seen(sync_seen));

/* File: test/tb.sv */
/*
  tb: self-checking bench for iqpc_regs.
  assumes: checker bound separately; ext_sync pulsed once, after the first sync.
*/
`timescale 1ns/10ps
module tb
  import iqpc_pkg::*;
;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic ext_sync = 1'h0;
  logic [15:0] reg_rdata;
  logic signed [15:0] a_in = 16'h0000;
  logic signed [15:0] b_in = 16'h0000;
  logic signed [15:0] a_out;
  logic signed [15:0] b_out;
  logic sync_seen;
  int mismatches = 0;
  int check_count = 0;
  logic [7:0] row_a [4] = '{8'h0c, 8'h0d, 8'h11, 8'h50};
  logic [15:0] row_w [4] = '{16'hfa00, 16'h0300, 16'hffff, 16'habcd};
  logic [15:0] row_r [4] = '{16'h0200, 16'h0300, 16'h0000, 16'h0000};
  always #5 ref_clk = ~ref_clk;
  iqpc_regs iqpc_regs_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_sync(ext_sync), .a_in(a_in), .b_in(b_in), .a_out(a_out), .b_out(b_out),
    .sync_seen(sync_seen));
  // ----
  // tasks: one bus call per cycle, so no strobe is assigned twice in a step
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'h1, 1'h0, a, d);
    bus(1'h0, 1'h0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    bus(1'h0, 1'h1, a, 16'h0000);
    bus(1'h0, 1'h0, a, 16'h0000);
    @(negedge ref_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic smp(input logic [15:0] a, input logic [15:0] b, input logic [15:0] exp);
    @(posedge ref_clk);
    a_in <= a;
    b_in <= b;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(a_out, exp);
  endtask
  task automatic complete_run();
    $display("mismatches %0d check_count %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----
  // sequence: gains 0x200 and 0x300, phase 0x800 = -0.5
  // ----
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd(IQPC_PHASE_CTRL_OFS, IQPC_PHASE_RST);
    rd(IQPC_CHAN_A_GAIN_OFS, IQPC_GAIN_RST);
    smp(16'h03e8, 16'h0190, 16'h03e8);
    for (int i = 0; i < 4; i++) begin
      wr(row_a[i], row_w[i]);
      rd(row_a[i], row_r[i]);
    end
    wr(IQPC_PHASE_CTRL_OFS, 16'h3800);
    rd(IQPC_PHASE_CTRL_OFS, 16'h3800);
    smp(16'h03e8, 16'h0190, 16'h03e8);
    chk({15'h0000, sync_seen}, 16'h0000);
    wr(IQPC_SYNC_SETUP_OFS, 16'h0001);
    bus(1'h1, 1'h0, IQPC_PHASE_CTRL_OFS, 16'h3800);
    rd(IQPC_PHASE_CTRL_OFS, 16'h3800);
    smp(16'h03e8, 16'h0190, 16'h012c);
    chk(b_out, 16'h012c);
    chk({15'h0000, sync_seen}, 16'h0001);
    // a gain write after the sync must stay staged only
    wr(IQPC_CHAN_A_GAIN_OFS, 16'h0400);
    smp(16'hfc18, 16'h0190, 16'hfd44);
    // offsets -5 and +5 stay staged until the pin edge syncs everything
    wr(IQPC_OFFSET_A_OFS, 16'h1ffb);
    wr(IQPC_OFFSET_B_OFS, 16'h0005);
    rd(IQPC_OFFSET_A_OFS, 16'h1ffb);
    smp(16'hfc18, 16'h0190, 16'hfd44);
    @(posedge ref_clk);
    ext_sync <= 1'h1;
    repeat (6) @(posedge ref_clk);
    ext_sync <= 1'h0;
    smp(16'hfc18, 16'h0190, 16'hfb4b);
    chk(b_out, 16'h0131);
    @(posedge ref_clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd(IQPC_PHASE_CTRL_OFS, IQPC_PHASE_RST);
    smp(16'h03e8, 16'h0190, 16'h03e8);
    chk({15'h0000, sync_seen}, 16'h0000);
    complete_run();
  end
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule
